/* pp_pkg.sv */
// Shared constants, types and selector decode for the post-processing block.
// Assumes a single 250 MHz clock domain and an AXI4-Lite register bus.
package pp_pkg;

  localparam int AXI_ADDR_W = 12;
  localparam int RESULT_W = 24;

  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_SEL_S1_12 = 10'h038;
  localparam logic [9:0] IDX_SEL_S1_34 = 10'h039;
  localparam logic [9:0] IDX_SEL_S1_56 = 10'h03a;
  localparam logic [9:0] IDX_SEL_S1_78 = 10'h03b;
  localparam logic [9:0] IDX_SEL_S2_12 = 10'h03c;
  localparam logic [9:0] IDX_SEL_S2_34 = 10'h03d;
  localparam logic [9:0] IDX_SEQ_CONFIG = 10'h043;
  localparam logic [9:0] IDX_OFFSET_CH1 = 10'h060;
  localparam logic [9:0] IDX_OFFSET_CH2 = 10'h061;
  localparam logic [9:0] IDX_STATUS = 10'h062;
  localparam int SEL_REGS = 6;

  // Reset values
  localparam logic [7:0] SEL_RESET = 8'h00;
  localparam logic [7:0] CONFIG_RESET = 8'h00;

  // Sequence configuration field positions
  localparam int CFG_SEQ2_EN = 7;
  localparam int CFG_SEQ2_CNT_LO = 4;
  localparam int CFG_SEQ1_EN = 3;
  localparam int CFG_SEQ1_CNT_LO = 0;

  // Status field positions
  localparam int STAT_DROP_LO = 8;
  localparam int STAT_LOADED_LO = 16;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    OP_PASS,
    OP_INVERT,
    OP_SUBTRACT,
    OP_LOAD
  } post_op_t;

  typedef struct packed {
    logic [AXI_ADDR_W-1:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [AXI_ADDR_W-1:0] araddr;
    logic arvalid;
    logic rready;
  } axil_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } axil_rsp_t;

  // One conversion result with its tag
  typedef struct packed {
    logic chan;
    logic seq;
    logic [2:0] sub;
    logic [RESULT_W-1:0] data;
  } sample_t;

  // Bit position of a selector in the flat 48-bit selector vector
  function automatic logic [5:0] sel_lsb(input logic seq, input logic [2:0] sub,
                                         input logic chan);
    logic [3:0] lin;
    logic [5:0] byte_base;
    logic [1:0] slot;
    lin = seq ? {2'h2, sub[1:0]} : {1'h0, sub};
    byte_base = {lin[3:1], 3'h0};
    slot = 2'h3 - {lin[0], chan};
    sel_lsb = byte_base + {3'h0, slot, 1'h0};
  endfunction

endpackage

/* axil_reg_slave.sv */
// AXI4-Lite slave front end: handshakes, response channels, one access each way.
// Assumes the parent decodes addresses combinationally from the take strobes.
`timescale 1ns/10ps
`default_nettype none

module axil_reg_slave (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire pp_pkg::axil_req_t axi_req_i,
  output pp_pkg::axil_rsp_t axi_rsp_o,
  output logic wr_take_o,
  output logic [pp_pkg::AXI_ADDR_W-1:0] wr_addr_o,
  output logic [31:0] wr_data_o,
  output logic [3:0] wr_strb_o,
  input wire logic wr_err_i,
  output logic rd_take_o,
  output logic [pp_pkg::AXI_ADDR_W-1:0] rd_addr_o,
  input wire logic [31:0] rd_data_i,
  input wire logic rd_err_i
);
  import pp_pkg::*;

  logic aw_full_r;
  logic [AXI_ADDR_W-1:0] aw_addr_r;
  logic w_full_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic aw_in;
  logic w_in;

  //////////////////////////////////////////////////////////////////////////////
  // Address and data may arrive in either order; the first to arrive is parked until the other is in
  assign axi_rsp_o.awready = ce_i & ~aw_full_r & ~bvalid_r;
  assign axi_rsp_o.wready = ce_i & ~w_full_r & ~bvalid_r;
  assign aw_in = axi_req_i.awvalid & axi_rsp_o.awready;
  assign w_in = axi_req_i.wvalid & axi_rsp_o.wready;
  assign wr_take_o = ce_i & ~bvalid_r & (aw_full_r | aw_in) & (w_full_r | w_in);
  assign wr_addr_o = aw_full_r ? aw_addr_r : axi_req_i.awaddr;
  assign wr_data_o = w_full_r ? w_data_r : axi_req_i.wdata;
  assign wr_strb_o = w_full_r ? w_strb_r : axi_req_i.wstrb;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aw_full_r <= 1'b0;
      aw_addr_r <= '0;
    end else if (ce_i) begin
      if (wr_take_o) begin
        aw_full_r <= 1'b0;
      end else if (aw_in) begin
        aw_full_r <= 1'b1;
        aw_addr_r <= axi_req_i.awaddr;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      w_full_r <= 1'b0;
      w_data_r <= 32'h0;
      w_strb_r <= 4'h0;
    end else if (ce_i) begin
      if (wr_take_o) begin
        w_full_r <= 1'b0;
      end else if (w_in) begin
        w_full_r <= 1'b1;
        w_data_r <= axi_req_i.wdata;
        w_strb_r <= axi_req_i.wstrb;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else if (ce_i) begin
      if (wr_take_o) begin
        bvalid_r <= 1'b1;
        bresp_r <= wr_err_i ? RESP_SLVERR : RESP_OKAY;
      end else if (axi_req_i.bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  assign axi_rsp_o.bvalid = bvalid_r;
  assign axi_rsp_o.bresp = bresp_r;

  //////////////////////////////////////////////////////////////////////////////
  // Read: one outstanding, data captured at the address handshake
  assign axi_rsp_o.arready = ce_i & ~rvalid_r;
  assign rd_take_o = axi_req_i.arvalid & axi_rsp_o.arready;
  assign rd_addr_o = axi_req_i.araddr;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0;
      rresp_r <= RESP_OKAY;
    end else if (ce_i) begin
      if (rd_take_o) begin
        rvalid_r <= 1'b1;
        rdata_r <= rd_data_i;
        rresp_r <= rd_err_i ? RESP_SLVERR : RESP_OKAY;
      end else if (axi_req_i.rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  assign axi_rsp_o.rvalid = rvalid_r;
  assign axi_rsp_o.rdata = rdata_r;
  assign axi_rsp_o.rresp = rresp_r;

endmodule

`default_nettype wire

/* pp_post_op.sv */
// Combinational post-processing operation on one result.
// Assumes the caller registers the answer and owns the offset store.
`timescale 1ns/10ps
`default_nettype none

module pp_post_op #(
  parameter int WIDTH = pp_pkg::RESULT_W
) (
  input wire pp_pkg::post_op_t op_i,
  input wire logic [WIDTH-1:0] data_i,
  input wire logic [WIDTH-1:0] offset_i,
  output logic [WIDTH-1:0] data_o,
  output logic load_o
);
  import pp_pkg::*;

  // Two's complement wrap on overflow; no saturation
  always_comb begin
    load_o = 1'b0;
    unique case (op_i)
      OP_PASS: data_o = data_i;
      OP_INVERT: data_o = WIDTH'(~data_i + 1'b1);
      OP_SUBTRACT: data_o = WIDTH'(data_i - offset_i);
      OP_LOAD: begin
        data_o = data_i;
        load_o = 1'b1;
      end
    endcase
  end

endmodule

`default_nettype wire

/* subsample_post_processing.sv */
// Top of the sub-sample post-processing stage with its register file.
// Assumes results arrive tagged on the system clock, one per cycle at most.
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none

module subsample_post_processing #(
  parameter int CHANNELS = 2,
  parameter int COUNT_W = 8
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire pp_pkg::axil_req_t axi_req_i,
  output pp_pkg::axil_rsp_t axi_rsp_o,
  input wire logic res_valid_i,
  input wire pp_pkg::sample_t res_i,
  output logic pp_valid_o,
  output pp_pkg::sample_t pp_o
);
  import pp_pkg::*;

  logic wr_take;
  logic [AXI_ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_err;
  logic rd_take;
  logic [AXI_ADDR_W-1:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_err;
  logic [9:0] wr_idx;
  logic [9:0] rd_idx;
  logic [7:0] sel_r [SEL_REGS];
  logic [7:0] config_r;
  logic [SEL_REGS*8-1:0] sel_flat;
  logic [RESULT_W-1:0] offset_r [CHANNELS];
  logic [CHANNELS-1:0] loaded_r;
  logic [COUNT_W-1:0] done_cnt_r;
  logic [COUNT_W-1:0] drop_cnt_r;
  logic active;
  logic [2:0] seq1_last;
  logic [2:0] seq2_last;
  logic [5:0] lsb;
  post_op_t op;
  logic [RESULT_W-1:0] op_data;
  logic op_load;
  logic pp_valid_r;
  sample_t pp_r;

  //////////////////////////////////////////////////////////////////////////////
  // Bus slave
  axil_reg_slave u_slave (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .axi_req_i(axi_req_i),
    .axi_rsp_o(axi_rsp_o),
    .wr_take_o(wr_take),
    .wr_addr_o(wr_addr),
    .wr_data_o(wr_data),
    .wr_strb_o(wr_strb),
    .wr_err_i(wr_err),
    .rd_take_o(rd_take),
    .rd_addr_o(rd_addr),
    .rd_data_i(rd_data),
    .rd_err_i(rd_err)
  );

  assign wr_idx = wr_addr[11:2];
  assign rd_idx = rd_addr[11:2];

  // Register index to selector slot, or SEL_REGS when not a selector
  function automatic logic [2:0] sel_slot(input logic [9:0] idx);
    if (idx >= IDX_SEL_S1_12 && idx <= IDX_SEL_S2_34) begin
      sel_slot = 3'(idx - IDX_SEL_S1_12);
    end else begin
      sel_slot = 3'(SEL_REGS);
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Write decode; offsets and status are read-only and answer with an error
  always_comb begin
    wr_err = 1'b1;
    if (sel_slot(wr_idx) != 3'(SEL_REGS) || wr_idx == IDX_SEQ_CONFIG) begin
      wr_err = 1'b0;
    end
  end

  // Eight-bit registers sit in byte lane 0 only
  generate
    for (genvar g = 0; g < SEL_REGS; g++) begin : g_sel
      always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          sel_r[g] <= SEL_RESET;
        end else if (ce_i && wr_take && wr_strb[0] && sel_slot(wr_idx) == 3'(g)) begin
          sel_r[g] <= wr_data[7:0];
        end
      end
      assign sel_flat[g*8 +: 8] = sel_r[g];
    end
  endgenerate

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      config_r <= CONFIG_RESET;
    end else if (ce_i && wr_take && wr_strb[0] && wr_idx == IDX_SEQ_CONFIG) begin
      config_r <= wr_data[7:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read decode; unused upper bits read as zero
  always_comb begin
    rd_data = 32'h0;
    rd_err = 1'b0;
    if (sel_slot(rd_idx) != 3'(SEL_REGS)) begin
      rd_data[7:0] = sel_r[sel_slot(rd_idx)];
    end else if (rd_idx == IDX_SEQ_CONFIG) begin
      rd_data[7:0] = config_r;
    end else if (rd_idx == IDX_OFFSET_CH1) begin
      rd_data[RESULT_W-1:0] = offset_r[0];
    end else if (rd_idx == IDX_OFFSET_CH2) begin
      rd_data[RESULT_W-1:0] = offset_r[1];
    end else if (rd_idx == IDX_STATUS) begin
      rd_data[COUNT_W-1:0] = done_cnt_r;
      rd_data[STAT_DROP_LO +: COUNT_W] = drop_cnt_r;
      rd_data[STAT_LOADED_LO +: CHANNELS] = loaded_r;
    end else begin
      rd_err = 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Active check: sub index is zero-based, counts are stored as n-1
  assign seq1_last = config_r[CFG_SEQ1_CNT_LO +: 3];
  assign seq2_last = {1'b0, config_r[CFG_SEQ2_CNT_LO +: 2]};

  always_comb begin
    if (res_i.seq) begin
      active = config_r[CFG_SEQ2_EN] && res_i.sub <= seq2_last;
    end else begin
      active = config_r[CFG_SEQ1_EN] && res_i.sub <= seq1_last;
    end
  end

  assign lsb = sel_lsb(res_i.seq, res_i.sub, res_i.chan);
  assign op = post_op_t'(sel_flat[lsb +: 2]);

  pp_post_op #(
    .WIDTH(RESULT_W)
  ) u_op (
    .op_i(op),
    .data_i(res_i.data),
    .offset_i(offset_r[res_i.chan]),
    .data_o(op_data),
    .load_o(op_load)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Per-channel offset store, held until that channel loads again
  generate
    for (genvar c = 0; c < CHANNELS; c++) begin : g_ofs
      always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          offset_r[c] <= '0;
          loaded_r[c] <= 1'b0;
        end else if (ce_i && res_valid_i && active && op_load && res_i.chan == 1'(c)) begin
          offset_r[c] <= res_i.data;
          loaded_r[c] <= 1'b1;
        end
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Registered output; inactive sub-samples are dropped, not forwarded
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pp_valid_r <= 1'b0;
      pp_r <= '0;
    end else if (ce_i) begin
      pp_valid_r <= res_valid_i & active;
      if (res_valid_i && active) begin
        pp_r.chan <= res_i.chan;
        pp_r.seq <= res_i.seq;
        pp_r.sub <= res_i.sub;
        pp_r.data <= op_data;
      end
    end
  end

  assign pp_valid_o = pp_valid_r;
  assign pp_o = pp_r;

  // Counters wrap; status is diagnostic only
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      done_cnt_r <= '0;
      drop_cnt_r <= '0;
    end else if (ce_i && res_valid_i) begin
      if (active) begin
        done_cnt_r <= COUNT_W'(done_cnt_r + 1'b1);
      end else begin
        drop_cnt_r <= COUNT_W'(drop_cnt_r + 1'b1);
      end
    end
  end

endmodule

`default_nettype wire

/* pp_chan_model.sv */
// Behavioural model of the two conversion channels feeding results.
// Assumes calls come right after a rising edge of the clock.
`timescale 1ns/10ps
`default_nettype none

module pp_chan_model (
  input wire logic clk_i,
  output logic valid_o,
  output pp_pkg::sample_t res_o
);
  import pp_pkg::*;

  initial begin
    valid_o = 1'b0;
    res_o = '0;
  end

  ////////////////////////////////////////
  // One result per call; calls may follow back to back
  task automatic send(input logic c, input logic s, input logic [2:0] n,
                      input logic [RESULT_W-1:0] d);
    valid_o <= 1'b1;
    res_o <= '{c, s, n, d};
    @(posedge clk_i);
  endtask

  // Released data flips so a stale value is never mistaken for a result
  task automatic idle;
    valid_o <= 1'b0;
    res_o <= ~res_o;
  endtask
endmodule

`default_nettype wire

/* pp_post_sva.sv */
// Port-level assertions for the post-processing top.
// Assumes one clock domain; bound onto the top module below.
`timescale 1ns/10ps
`default_nettype none

module pp_post_checker #(
  parameter int CHANNELS = 2,
  parameter int COUNT_W = 8
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire pp_pkg::axil_req_t axi_req_i,
  input wire pp_pkg::axil_rsp_t axi_rsp_o,
  input wire logic res_valid_i,
  input wire pp_pkg::sample_t res_i,
  input wire logic pp_valid_o,
  input wire pp_pkg::sample_t pp_o
);
  import pp_pkg::*;
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  ////////////////////////////////////////
  // A frozen enable may stretch a pulse, hence the enable term
  a_out_cause: assert property (pp_valid_o && $past(ce_i) |-> $past(res_valid_i))
    else $error("output without result");
  a_out_tag: assert property (pp_valid_o && $past(ce_i) |-> pp_o.chan == $past(res_i.chan)
    && pp_o.seq == $past(res_i.seq) && pp_o.sub == $past(res_i.sub)) else $error("tag");
  a_seq2_drop: assert property (res_valid_i && ce_i && res_i.seq && res_i.sub[2]
    |=> !pp_valid_o) else $error("inactive forwarded");
  a_out_hold: assert property (!pp_valid_o |-> $stable(pp_o)) else $error("output moved");
  a_wr_resp: assert property (axi_req_i.awvalid && axi_rsp_o.awready && axi_req_i.wvalid
    && axi_rsp_o.wready |=> axi_rsp_o.bvalid) else $error("no write resp");
  a_b_hold: assert property (axi_rsp_o.bvalid && !axi_req_i.bready
    |=> axi_rsp_o.bvalid && $stable(axi_rsp_o.bresp)) else $error("bresp dropped");
  a_rd_resp: assert property (axi_req_i.arvalid && axi_rsp_o.arready |=> axi_rsp_o.rvalid)
    else $error("no read resp");
  a_r_hold: assert property (axi_rsp_o.rvalid && !axi_req_i.rready
    |=> axi_rsp_o.rvalid && $stable(axi_rsp_o.rdata)) else $error("rdata dropped");
  a_ce_freeze: assert property (!ce_i |-> !axi_rsp_o.awready && !axi_rsp_o.arready)
    else $error("ready while frozen");

  c_out: cover property (pp_valid_o);
  c_wr: cover property (axi_rsp_o.bvalid && axi_req_i.bready);
  c_rd_err: cover property (axi_rsp_o.rvalid && axi_rsp_o.rresp == RESP_SLVERR);
endmodule

bind subsample_post_processing pp_post_checker #(.CHANNELS(CHANNELS), .COUNT_W(COUNT_W))
  pp_post_checker_inst (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
  .axi_req_i(axi_req_i), .axi_rsp_o(axi_rsp_o), .res_valid_i(res_valid_i),
  .res_i(res_i), .pp_valid_o(pp_valid_o), .pp_o(pp_o));

`default_nettype wire

/* testbench.sv */
// Self-checking bench for the sub-sample post-processing stage.
// Assumes the channel model and the bound checker are compiled first.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e, m) begin tests_run++; if ((a) !== (e)) begin fail_count++; $display("mismatch %0t %s", $time, m); end end

module testbench;
  import pp_pkg::*;
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic ce_i = 1'b1;
  axil_req_t req = '0;
  axil_rsp_t rsp;
  logic res_valid;
  logic pp_valid;
  sample_t res;
  sample_t pp;
  int fail_count = 0;
  int tests_run = 0;
  int cyc = 0;
  logic [7:0] sel [6];
  logic [RESULT_W-1:0] off [2] = '{default: '0};
  sample_t got [$];
  sample_t exp [$];

  always #2 sys_clk_i = ~sys_clk_i;

  subsample_post_processing subsample_post_processing_inst (.sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i), .ce_i(ce_i), .axi_req_i(req), .axi_rsp_o(rsp),
    .res_valid_i(res_valid), .res_i(res), .pp_valid_o(pp_valid), .pp_o(pp));
  pp_chan_model pp_chan_model_inst (.clk_i(sys_clk_i), .valid_o(res_valid), .res_o(res));

  // Mid-cycle sampling keeps clear of edge races
  always @(negedge sys_clk_i) if (pp_valid === 1'b1) got.push_back(pp);

  task automatic conclude;
    if (fail_count == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fail_count++;
      conclude();
    end
  end

  ////////////////////////////////////////
  // A lag keeps bready low for that many answer cycles, so the held response is exercised
  task automatic wr(input logic [11:0] a, input logic [7:0] d, output logic [1:0] r,
                    input int lag = 0);
    logic aw, w, b;
    req.awaddr <= a;
    req.wdata <= {24'h0, d};
    req.wstrb <= 4'hf;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= (lag == 0);
    do begin
      @(negedge sys_clk_i);
      aw = req.awvalid & rsp.awready;
      w = req.wvalid & rsp.wready;
      b = rsp.bvalid & req.bready;
      if (rsp.bvalid === 1'b1 && lag > 0) lag--;
      r = rsp.bresp;
      @(posedge sys_clk_i);
      if (aw) req.awvalid <= 1'b0;
      if (w) req.wvalid <= 1'b0;
      if (lag == 0 && b !== 1'b1) req.bready <= 1'b1;
    end while (b !== 1'b1);
    req.bready <= 1'b0;
    @(posedge sys_clk_i);
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r,
                    input int lag = 0);
    logic h, v;
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= (lag == 0);
    do begin
      @(negedge sys_clk_i);
      h = req.arvalid & rsp.arready;
      v = rsp.rvalid & req.rready;
      if (rsp.rvalid === 1'b1 && lag > 0) lag--;
      d = rsp.rdata;
      r = rsp.rresp;
      @(posedge sys_clk_i);
      if (h) req.arvalid <= 1'b0;
      if (lag == 0 && v !== 1'b1) req.rready <= 1'b1;
    end while (v !== 1'b1);
    req.rready <= 1'b0;
    @(posedge sys_clk_i);
  endtask

  // Expected result from the selector layout, then the send
  task automatic put(input logic c, input logic s, input logic [2:0] n, input logic [23:0] d);
    logic [1:0] code;
    logic [23:0] e;
    code = sel[s ? 4 + n[1] : n[2:1]][6 - 2 * (2 * n[0] + c) +: 2];
    case (code)
      2'h0: e = d;
      2'h1: e = -d;
      2'h2: e = d - off[c];
      default: begin
        e = d;
        off[c] = d;
      end
    endcase
    exp.push_back(sample_t'{c, s, n, e});
    pp_chan_model_inst.send(c, s, n, d);
  endtask

  task automatic judge(input string m);
    pp_chan_model_inst.idle();
    repeat (3) @(posedge sys_clk_i);
    `CHK(got.size(), exp.size(), m)
    while (got.size() > 0 && exp.size() > 0) `CHK(got.pop_front(), exp.pop_front(), m)
    got.delete();
    exp.delete();
  endtask

  ////////////////////////////////////////
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0] r;
    logic [11:0] a;
    for (int i = 0; i < 7; i++) begin
      a = i < 6 ? 12'h0e0 + 12'(4 * i) : 12'h10c;
      rd(a, d, r);
      `CHK(d, 32'h0, "reset value")
      `CHK(r, RESP_OKAY, "reset resp")
    end
    rd(12'h000, d, r);
    `CHK(r, RESP_SLVERR, "unmapped read")
    wr(12'h188, 8'hff, r);
    `CHK(r, RESP_SLVERR, "read-only write")
    for (int i = 0; i < 6; i++) begin
      a = 12'h0e0 + 12'(4 * i);
      wr(a, 8'hc6 - 8'(17 * i), r, i % 3);
      rd(a, d, r, i % 3);
      `CHK(d, {24'h0, 8'hc6 - 8'(17 * i)}, "readback")
    end
  endtask

  // Each byte sees all four patterns, so every field takes every code
  task automatic t_ops;
    logic [7:0] pat [4] = '{8'h1b, 8'he4, 8'h4e, 8'hb1};
    logic [1:0] r;
    logic [31:0] d;
    wr(12'h10c, 8'hbf, r);
    for (int k = 0; k < 4; k++) begin
      for (int i = 0; i < 6; i++) begin
        sel[i] = pat[(k + i) % 4];
        wr(12'h0e0 + 12'(4 * i), sel[i], r);
      end
      for (int j = 0; j < 24; j++)
        put(1'(j), j >= 16, 3'(j < 16 ? j / 2 : (j - 16) / 2), 24'h5a0000 + 24'(k * 4951 + j * 177));
      pp_chan_model_inst.send(1'b0, 1'b1, 3'h4, 24'h1);
      judge("post op");
    end
    rd({IDX_OFFSET_CH1, 2'h0}, d, r);
    `CHK(d, {8'h0, off[0]}, "offset ch1")
    rd({IDX_OFFSET_CH2, 2'h0}, d, r);
    `CHK(d, {8'h0, off[1]}, "offset ch2")
  endtask

  task automatic t_drop;
    logic [1:0] r;
    logic [31:0] d;
    wr(12'h10c, 8'h0a, r);
    for (int j = 0; j < 8; j++) begin
      if (j < 3) put(1'b1, 1'b0, 3'(j), 24'h0c0de0 + 24'(j));
      else pp_chan_model_inst.send(1'b1, 1'b0, 3'(j), 24'h7);
    end
    pp_chan_model_inst.send(1'b0, 1'b1, 3'h0, 24'h9);
    pp_chan_model_inst.idle();
    @(posedge sys_clk_i);
    ce_i <= 1'b0;
    pp_chan_model_inst.send(1'b0, 1'b0, 3'h0, 24'h5);
    ce_i <= 1'b1;
    judge("inactive");
    // 99 processed, 10 dropped, the frozen one uncounted; both offsets loaded
    rd({IDX_STATUS, 2'h0}, d, r);
    `CHK(d, {14'h0, 2'h3, 8'h0a, 8'h63}, "status")
  endtask

  initial begin
    repeat (16) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    @(posedge sys_clk_i);
    t_regs();
    t_ops();
    t_drop();
    conclude();
  end
endmodule

`default_nettype wire
